/* File: hdl/rcs_map.svh */
`ifndef RCS_MAP_SVH
`define RCS_MAP_SVH
// Register indexes; byte address is four times the index
`define RCS_IDX_CMD 8'h01
`define RCS_IDX_STATUS 8'h07
`define RCS_IDX_GUARD 8'h21
`define RCS_IDX_SPARE_A 8'h3E
`define RCS_IDX_SPARE_B 8'h3F
// Operation codes
`define RCS_OP_IDLE 8'h00
`define RCS_OP_NVW 8'h01
`define RCS_OP_NVR 8'h03
`define RCS_OP_KEYN 8'h0B
`define RCS_OP_RX 8'h16
`define RCS_OP_KEYQ 8'h19
`define RCS_OP_TX 8'h1A
`define RCS_OP_TRX 8'h1E
`define RCS_OP_POWER_UP_INIT_OP 8'h3F
// Reset values
`define RCS_RST_CMD 8'h3F
`define RCS_RST_GUARD 8'h06
// Status fields
`define RCS_STAT_BUSY 0
`define RCS_STAT_REFUSED 1
// Operand counts and sizes
`define RCS_ARGS_ADDR 2'h2
`define RCS_ARGS_NVR 2'h3
`define RCS_KEY_BYTES 12
`define RCS_KEY_BASE 16'h0080
// Timing counts in clock cycles
`define RCS_GUARD_TICK 16
`define RCS_POWER_UP_INIT_OP_CYCLES 64
`endif

/* File: hdl/rcs_pkg.sv */
`include "rcs_map.svh"
package rcs_pkg;
	typedef logic [7:0] rcs_byte_t;
	typedef enum logic [9:0] {
		ST_POWER_UP_INIT_OP = 10'b00_0000_0001,
		ST_IDLE = 10'b00_0000_0010,
		ST_TX = 10'b00_0000_0100,
		ST_GUARD = 10'b00_0000_1000,
		ST_RX = 10'b00_0001_0000,
		ST_ARGS = 10'b00_0010_0000,
		ST_NVW = 10'b00_0100_0000,
		ST_NVR = 10'b00_1000_0000,
		ST_KEYN = 10'b01_0000_0000,
		ST_KEYQ = 10'b10_0000_0000
	} rcs_state_e;

	// Byte address of a register index
	function automatic rcs_byte_t rcs_byte_addr(input rcs_byte_t idx);
		return {idx[5:0], 2'b00};
	endfunction : rcs_byte_addr

	// Operand bytes an operation needs before it may start
	function automatic logic [1:0] rcs_args_needed(input rcs_byte_t op);
		return (op == `RCS_OP_NVR) ? `RCS_ARGS_NVR : `RCS_ARGS_ADDR;
	endfunction : rcs_args_needed
endpackage : rcs_pkg

/* File: hdl/rcs_nvm_if.sv */
interface rcs_nvm_if;
	logic we;
	logic [15:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport ctrl (output we, output addr, output wdata, input rdata);
	modport mem (input we, input addr, input wdata, output rdata);
endinterface : rcs_nvm_if

/* File: hdl/rcs_nvm_mem.sv */
module rcs_nvm_mem #(
	parameter int DEPTH = 512
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Access port
	rcs_nvm_if.mem nvm
);
	localparam int AW = $clog2(DEPTH);
	logic [7:0] cells [DEPTH];
	logic [7:0] next_rdata;

	generate
		if (DEPTH < 2 || DEPTH > 65536 || (1 << AW) != DEPTH) begin : g_bad_depth
			$error("nvm depth must be a power of two up to 65536");
		end
	endgenerate

	// Array left unreset, as a real storage array would be
	always_ff @(posedge clock_i) begin
		if (nvm.we) begin
			cells[nvm.addr[AW-1:0]] <= nvm.wdata;
		end
	end

	// Registered read, one cycle after the address
	always_comb begin
		next_rdata = cells[nvm.addr[AW-1:0]];
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			nvm.rdata <= 8'h00;
		end else begin
			nvm.rdata <= next_rdata;
		end
	end
endmodule : rcs_nvm_mem

/* File: hdl/rcs_guard_timer.sv */
module rcs_guard_timer (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Control
	input wire logic load_i,
	input wire logic [23:0] count_i,
	// Status
	output logic expired_o
);
	logic [23:0] count;
	logic [23:0] next_count;

	// Count down to zero and rest there
	always_comb begin
		if (load_i) begin
			next_count = count_i;
		end else if (count != 24'h00_0000) begin
			next_count = count - 24'h00_0001;
		end else begin
			next_count = count;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count <= 24'h00_0000;
		end else begin
			count <= next_count;
		end
	end

	assign expired_o = (count == 24'h00_0000);
endmodule : rcs_guard_timer

/* File: hdl/rcs_sequencer.sv */
// Register access over APB was chosen for this implementation.
`include "rcs_map.svh"
module rcs_sequencer #(
	parameter int NVM_DEPTH = 512,
	parameter int KEY_BYTES = `RCS_KEY_BYTES,
	parameter int GUARD_TICK = `RCS_GUARD_TICK,
	parameter int POWER_UP_INIT_OP_CYCLES = `RCS_POWER_UP_INIT_OP_CYCLES
) (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_N_I,
	// APB slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire rcs_pkg::rcs_byte_t PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// Queue read side
	input wire logic QUEUE_VALID_I,
	input wire rcs_pkg::rcs_byte_t QUEUE_DATA_I,
	output logic QUEUE_POP_O,
	// Queue write side
	output logic QUEUE_PUSH_O,
	output rcs_pkg::rcs_byte_t QUEUE_PUSH_DATA_O,
	// Transmitter
	output logic TX_VALID_O,
	output rcs_pkg::rcs_byte_t TX_DATA_O,
	input wire logic TX_READY_I,
	output logic TX_END_O,
	// Receiver
	output logic RX_ENABLE_O,
	input wire logic RX_VALID_I,
	input wire rcs_pkg::rcs_byte_t RX_DATA_I,
	input wire logic RX_END_I,
	// Key buffer
	output logic KEY_WE_O,
	output logic [3:0] KEY_INDEX_O,
	output rcs_pkg::rcs_byte_t KEY_DATA_O
);
	import rcs_pkg::*;

	generate
		if (KEY_BYTES < 1 || KEY_BYTES > 16 || GUARD_TICK < 1 || GUARD_TICK > 65535
			|| POWER_UP_INIT_OP_CYCLES < 1 || POWER_UP_INIT_OP_CYCLES > 65535) begin : g_bad_param
			$error("rcs_sequencer parameter out of range");
		end
	endgenerate

	rcs_state_e state, next_state;
	rcs_byte_t cmd, next_cmd, guard, next_guard;
	logic refused, next_refused, set_refused;
	logic trx, next_trx;
	logic [1:0] arg_cnt, next_arg_cnt, rd_phase, next_rd_phase;
	logic [15:0] addr, next_addr;
	rcs_byte_t remain, next_remain;
	logic [3:0] key_idx, next_key_idx, next_key_index;
	logic next_q_pop, next_push, next_tx_valid, next_tx_end, next_rx_en, next_key_we;
	rcs_byte_t next_push_data, next_tx_data, next_key_data;
	logic nv_we, next_nv_we;
	logic [15:0] nv_addr, next_nv_addr;
	rcs_byte_t nv_wdata, next_nv_wdata;
	logic tmr_load, next_tmr_load, tmr_expired;
	logic [23:0] tmr_count, next_tmr_count;
	logic next_pready, next_pslverr;
	logic [31:0] next_prdata;
	logic apb_wr, cmd_wr, take, tmr_done, key_area;
	rcs_byte_t wop;

	rcs_nvm_if nvm ();

	rcs_nvm_mem #(.DEPTH(NVM_DEPTH)) u_nvm (
		.clock_i(CLOCK_I),
		.rst_n_i(RST_N_I),
		.nvm(nvm.mem)
	);

	rcs_guard_timer u_timer (
		.clock_i(CLOCK_I),
		.rst_n_i(RST_N_I),
		.load_i(tmr_load),
		.count_i(tmr_count),
		.expired_o(tmr_expired)
	);

	assign nvm.we = nv_we;
	assign nvm.addr = nv_addr;
	assign nvm.wdata = nv_wdata;

	// Bus strobes; writes count only at the completing edge
	assign apb_wr = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;
	assign wop = PWDATA_I[7:0];
	// Writes during init and the init code itself are ignored
	assign cmd_wr = apb_wr && PADDR_I == rcs_byte_addr(`RCS_IDX_CMD)
		&& state != ST_POWER_UP_INIT_OP && wop != `RCS_OP_POWER_UP_INIT_OP;
	assign take = QUEUE_POP_O & QUEUE_VALID_I;
	assign tmr_done = !tmr_load && tmr_expired;
	assign key_area = addr >= `RCS_KEY_BASE;

	// APB slave: one wait state, then registered answer
	always_comb begin
		next_pready = PSEL_I & PENABLE_I & !PREADY_O;
		next_prdata = 32'h0000_0000;
		next_pslverr = 1'b0;
		next_guard = guard;
		if (next_pready) begin
			unique case (PADDR_I)
				rcs_byte_addr(`RCS_IDX_CMD): next_prdata = {24'h00_0000, cmd};
				rcs_byte_addr(`RCS_IDX_STATUS): begin
					next_prdata[`RCS_STAT_BUSY] = state != ST_IDLE;
					next_prdata[`RCS_STAT_REFUSED] = refused;
				end
				rcs_byte_addr(`RCS_IDX_GUARD): next_prdata = {24'h00_0000, guard};
				rcs_byte_addr(`RCS_IDX_SPARE_A), rcs_byte_addr(`RCS_IDX_SPARE_B): ;
				default: next_pslverr = 1'b1;
			endcase
		end
		if (apb_wr && PADDR_I == rcs_byte_addr(`RCS_IDX_GUARD) && state != ST_POWER_UP_INIT_OP) begin
			next_guard = wop;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			PREADY_O <= 1'b0;
			PRDATA_O <= 32'h0000_0000;
			PSLVERR_O <= 1'b0;
			guard <= `RCS_RST_GUARD;
		end else begin
			PREADY_O <= next_pready;
			PRDATA_O <= next_prdata;
			PSLVERR_O <= next_pslverr;
			guard <= next_guard;
		end
	end

	// Sequencer; pops alternate so queue valid is fresh each time
	always_comb begin
		next_state = state;
		next_cmd = cmd;
		set_refused = 1'b0;
		next_trx = trx;
		next_arg_cnt = arg_cnt;
		next_rd_phase = rd_phase;
		next_addr = addr;
		next_remain = remain;
		next_key_idx = key_idx;
		next_key_index = KEY_INDEX_O;
		next_q_pop = 1'b0;
		next_push = 1'b0;
		next_push_data = QUEUE_PUSH_DATA_O;
		next_tx_valid = TX_VALID_O;
		next_tx_data = TX_DATA_O;
		next_tx_end = 1'b0;
		next_rx_en = RX_ENABLE_O;
		next_key_we = 1'b0;
		next_key_data = KEY_DATA_O;
		next_nv_we = 1'b0;
		next_nv_addr = nv_addr;
		next_nv_wdata = nv_wdata;
		next_tmr_load = 1'b0;
		next_tmr_count = tmr_count;
		unique case (state)
			ST_POWER_UP_INIT_OP: begin
				if (tmr_done) begin
					next_state = ST_IDLE;
					next_cmd = `RCS_OP_IDLE;
				end
			end
			ST_IDLE: ;
			ST_TX: begin
				// Starts on whatever the queue holds, ends when it runs dry
				if (TX_VALID_O) begin
					next_tx_valid = !TX_READY_I;
				end else if (take) begin
					next_tx_valid = 1'b1;
					next_tx_data = QUEUE_DATA_I;
				end else if (!QUEUE_POP_O && QUEUE_VALID_I) begin
					next_q_pop = 1'b1;
				end else if (!QUEUE_POP_O) begin
					next_tx_end = 1'b1;
					if (trx) begin
						next_state = ST_GUARD;
						next_tmr_load = 1'b1;
						next_tmr_count = 24'(guard) * 24'(GUARD_TICK);
					end else begin
						next_state = ST_IDLE;
						next_cmd = `RCS_OP_IDLE;
					end
				end
			end
			ST_GUARD: begin
				if (tmr_done) begin
					next_state = ST_RX;
					next_rx_en = 1'b1;
				end
			end
			ST_RX: begin
				if (RX_VALID_I) begin
					next_push = 1'b1;
					next_push_data = RX_DATA_I;
				end
				if (RX_END_I) begin
					next_rx_en = 1'b0;
					next_state = ST_IDLE;
					next_cmd = `RCS_OP_IDLE;
				end
			end
			ST_ARGS: begin
				// Address low byte, high byte, then count for reads
				if (take) begin
					unique case (arg_cnt)
						2'h0: next_addr[7:0] = QUEUE_DATA_I;
						2'h1: next_addr[15:8] = QUEUE_DATA_I;
						default: next_remain = QUEUE_DATA_I;
					endcase
					next_arg_cnt = 2'(arg_cnt + 2'h1);
					if (2'(arg_cnt + 2'h1) == rcs_args_needed(cmd)) begin
						if (cmd == `RCS_OP_NVW) begin
							next_state = ST_NVW;
						end else if (cmd == `RCS_OP_KEYN) begin
							next_state = ST_KEYN;
						end else if (QUEUE_DATA_I == 8'h00) begin
							next_state = ST_IDLE;
							next_cmd = `RCS_OP_IDLE;
						end else begin
							next_state = ST_NVR;
						end
					end
				end else if (!QUEUE_POP_O && QUEUE_VALID_I) begin
					next_q_pop = 1'b1;
				end
			end
			ST_NVW: begin
				// Runs until the host writes a new code
				if (take) begin
					next_nv_we = 1'b1;
					next_nv_addr = addr;
					next_nv_wdata = QUEUE_DATA_I;
					next_addr = addr + 16'h0001;
				end else if (!QUEUE_POP_O && QUEUE_VALID_I) begin
					next_q_pop = 1'b1;
				end
			end
			ST_NVR, ST_KEYN: begin
				// Phase 0 address, 1 wait, 2 data valid from memory
				unique case (rd_phase)
					2'h0: begin
						if (state == ST_NVR && key_area) begin
							set_refused = 1'b1;
							next_state = ST_IDLE;
							next_cmd = `RCS_OP_IDLE;
						end else begin
							next_nv_addr = addr;
							next_rd_phase = 2'h1;
						end
					end
					2'h1: next_rd_phase = 2'h2;
					default: begin
						next_rd_phase = 2'h0;
						next_addr = addr + 16'h0001;
						if (state == ST_NVR) begin
							next_push = 1'b1;
							next_push_data = nvm.rdata;
							next_remain = remain - 8'h01;
							if (remain == 8'h01) begin
								next_state = ST_IDLE;
								next_cmd = `RCS_OP_IDLE;
							end
						end else begin
							next_key_we = 1'b1;
							next_key_data = nvm.rdata;
							next_key_index = key_idx;
							next_key_idx = 4'(key_idx + 4'h1);
							if (key_idx == 4'(KEY_BYTES - 1)) begin
								next_state = ST_IDLE;
								next_cmd = `RCS_OP_IDLE;
							end
						end
					end
				endcase
			end
			ST_KEYQ: begin
				// Lowest key byte arrives first
				if (take) begin
					next_key_we = 1'b1;
					next_key_data = QUEUE_DATA_I;
					next_key_index = key_idx;
					next_key_idx = 4'(key_idx + 4'h1);
					if (key_idx == 4'(KEY_BYTES - 1)) begin
						next_state = ST_IDLE;
						next_cmd = `RCS_OP_IDLE;
					end
				end else if (!QUEUE_POP_O && QUEUE_VALID_I) begin
					next_q_pop = 1'b1;
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_cmd = `RCS_OP_IDLE;
			end
		endcase
		// A new code overrides all but a TX_END_O pulse, a guard timer load and the refused set; queue is left as it is
		if (cmd_wr) begin
			next_cmd = wop;
			next_q_pop = 1'b0;
			next_push = 1'b0;
			next_tx_valid = 1'b0;
			next_rx_en = 1'b0;
			next_key_we = 1'b0;
			next_nv_we = 1'b0;
			next_arg_cnt = 2'h0;
			next_rd_phase = 2'h0;
			next_key_idx = 4'h0;
			next_trx = wop == `RCS_OP_TRX;
			unique case (wop)
				`RCS_OP_TX, `RCS_OP_TRX: next_state = ST_TX;
				`RCS_OP_RX: begin
					next_state = ST_GUARD;
					next_tmr_load = 1'b1;
					next_tmr_count = 24'(guard) * 24'(GUARD_TICK);
				end
				`RCS_OP_NVW, `RCS_OP_NVR, `RCS_OP_KEYN: next_state = ST_ARGS;
				`RCS_OP_KEYQ: next_state = ST_KEYQ;
				default: begin
					next_state = ST_IDLE;
					next_cmd = `RCS_OP_IDLE;
				end
			endcase
		end
		// Hardware set beats the clear from a new command
		next_refused = (refused & !cmd_wr) | set_refused;
	end

	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state <= ST_POWER_UP_INIT_OP;
			cmd <= `RCS_RST_CMD;
			refused <= 1'b0;
			trx <= 1'b0;
			arg_cnt <= 2'h0;
			rd_phase <= 2'h0;
			addr <= 16'h0000;
			remain <= 8'h00;
			key_idx <= 4'h0;
			KEY_INDEX_O <= 4'h0;
			QUEUE_POP_O <= 1'b0;
			QUEUE_PUSH_O <= 1'b0;
			QUEUE_PUSH_DATA_O <= 8'h00;
			TX_VALID_O <= 1'b0;
			TX_DATA_O <= 8'h00;
			TX_END_O <= 1'b0;
			RX_ENABLE_O <= 1'b0;
			KEY_WE_O <= 1'b0;
			KEY_DATA_O <= 8'h00;
			nv_we <= 1'b0;
			nv_addr <= 16'h0000;
			nv_wdata <= 8'h00;
			tmr_load <= 1'b1;
			tmr_count <= 24'(POWER_UP_INIT_OP_CYCLES);
		end else begin
			state <= next_state;
			cmd <= next_cmd;
			refused <= next_refused;
			trx <= next_trx;
			arg_cnt <= next_arg_cnt;
			rd_phase <= next_rd_phase;
			addr <= next_addr;
			remain <= next_remain;
			key_idx <= next_key_idx;
			KEY_INDEX_O <= next_key_index;
			QUEUE_POP_O <= next_q_pop;
			QUEUE_PUSH_O <= next_push;
			QUEUE_PUSH_DATA_O <= next_push_data;
			TX_VALID_O <= next_tx_valid;
			TX_DATA_O <= next_tx_data;
			TX_END_O <= next_tx_end;
			RX_ENABLE_O <= next_rx_en;
			KEY_WE_O <= next_key_we;
			KEY_DATA_O <= next_key_data;
			nv_we <= next_nv_we;
			nv_addr <= next_nv_addr;
			nv_wdata <= next_nv_wdata;
			tmr_load <= next_tmr_load;
			tmr_count <= next_tmr_count;
		end
	end

	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!RST_N_I);

	chk_cmd_starts_tx: assert property (cmd_wr && wop == `RCS_OP_TX |=> state == ST_TX && cmd == `RCS_OP_TX)
		else $error("transmit code did not start transmit");
	chk_power_up_init_op_locked: assert property (state == ST_POWER_UP_INIT_OP |=> state == ST_POWER_UP_INIT_OP || state == ST_IDLE)
		else $error("init left by other than finishing");
	chk_idle_cancels: assert property (cmd_wr && wop == `RCS_OP_IDLE
		|=> state == ST_IDLE && !TX_VALID_O && !RX_ENABLE_O && !QUEUE_POP_O)
		else $error("idle code did not cancel");
	chk_args_pending: assert property (state == ST_ARGS && !cmd_wr
		&& !(take && 2'(arg_cnt + 2'h1) == rcs_args_needed(cmd)) |=> state == ST_ARGS)
		else $error("operation started before its operands");
	chk_rx_after_guard: assert property ($rose(RX_ENABLE_O) |-> $past(state) == ST_GUARD && $past(tmr_expired))
		else $error("receiver enabled before guard delay");
	chk_key_refused: assert property (state == ST_NVR && rd_phase == 2'h0 && key_area && !cmd_wr
		|=> refused && state == ST_IDLE && !QUEUE_PUSH_O)
		else $error("key area read not refused");
	chk_self_done_idle: assert property ($rose(state == ST_IDLE) && !$past(cmd_wr) |-> cmd == `RCS_OP_IDLE)
		else $error("finished operation left code set");
	chk_tx_pulls_queue: assert property (state == ST_TX && QUEUE_VALID_I && !QUEUE_POP_O && !TX_VALID_O && !cmd_wr
		|=> QUEUE_POP_O)
		else $error("transmit did not take queued byte");
	chk_new_cmd_wins: assert property (cmd_wr && wop == `RCS_OP_KEYQ |=> state == ST_KEYQ ##1 cmd == `RCS_OP_KEYQ
		|| state != ST_KEYQ)
		else $error("new code did not take over");
	chk_key_load: assert property (state == ST_KEYQ && take && !cmd_wr
		|=> KEY_WE_O && KEY_DATA_O == $past(QUEUE_DATA_I) && KEY_INDEX_O == $past(key_idx))
		else $error("queued key byte not loaded");

	cov_init_done: cover property (state == ST_POWER_UP_INIT_OP ##1 state == ST_IDLE);
	cov_transceive: cover property (state == ST_TX && trx ##[1:200] state == ST_RX);
	cov_nvm_read: cover property (state == ST_NVR ##[1:50] QUEUE_PUSH_O);
	cov_key_nvm: cover property (state == ST_KEYN ##[1:100] state == ST_IDLE);
endmodule : rcs_sequencer

/* File: tb/rcs_far_model.sv */
module rcs_far_model (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Queue
	input wire logic pop_i,
	input wire logic push_i,
	input wire logic [7:0] push_data_i,
	output logic valid_o,
	output logic [7:0] data_o,
	// Radio
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	output logic tx_ready_o,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	output logic rx_end_o,
	// Key buffer
	input wire logic key_we_i,
	input wire logic [3:0] key_index_i,
	input wire logic [7:0] key_data_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] q [256];
	int head = 0;
	int tail = 0;
	logic slow = 1'b0;
	logic [7:0] txd [$];
	logic [7:0] pushed [$];
	logic [7:0] keys [16];
	int nkey = 0;
	// Quiet outputs at time zero
	initial begin
		foreach (q[i])
			q[i] = 8'(i);
		tx_ready_o = 1'b0;
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
		rx_end_o = 1'b0;
	end
	// Empty queue shows the inverse of the last byte, never a stale head
	assign valid_o = head != tail;
	assign data_o = valid_o ? q[head[7:0]] : ~q[8'(head - 1)];
	// Consume, record and answer at each edge; slow mode halves the rate
	always @(posedge clock_i) begin
		if (pop_i && valid_o)
			head <= head + 1;
		if (push_i)
			pushed.push_back(push_data_i);
		if (tx_valid_i && tx_ready_o)
			txd.push_back(tx_data_i);
		tx_ready_o <= tx_valid_i && !(slow && tx_ready_o);
		if (key_we_i) begin
			keys[key_index_i] <= key_data_i;
			nkey <= nkey + 1;
		end
	end
	// Called right after a rising edge
	task automatic put(input logic [7:0] b);
		q[tail[7:0]] <= b;
		tail <= tail + 1;
		@(posedge clock_i);
	endtask : put
	// Received bytes, then the end pulse
	task automatic reply(input logic [7:0] d [$]);
		foreach (d[i]) begin
			rx_valid_o <= 1'b1;
			rx_data_o <= d[i];
			@(posedge clock_i);
			rx_valid_o <= 1'b0;
			rx_data_o <= ~d[i];
			@(posedge clock_i);
		end
		rx_end_o <= 1'b1;
		@(posedge clock_i);
		rx_end_o <= 1'b0;
	endtask : reply
endmodule : rcs_far_model

/* File: tb/test_reader_command_sequencer.sv */
`include "rcs_map.svh"
module test_reader_command_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	import rcs_pkg::*;
	localparam int TICK = 2;
	localparam int KB = 12;
	logic clk = 1'b0;
	logic rst_n;
	logic psel;
	logic penable;
	logic pwrite;
	rcs_byte_t paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready, pslverr, qv, pop, push, txv, txr, txe, rxen, rxv, rxe, kwe;
	rcs_byte_t qd, pushd, txd, rxd, kd;
	logic [3:0] kidx;
	int errors = 0;
	int n_compared = 0;
	// Shorter counts keep the run brief
	rcs_sequencer #(.NVM_DEPTH(512), .KEY_BYTES(KB), .GUARD_TICK(TICK), .POWER_UP_INIT_OP_CYCLES(20)) dut_u (
		.CLOCK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.QUEUE_VALID_I(qv), .QUEUE_DATA_I(qd), .QUEUE_POP_O(pop), .QUEUE_PUSH_O(push),
		.QUEUE_PUSH_DATA_O(pushd), .TX_VALID_O(txv), .TX_DATA_O(txd), .TX_READY_I(txr), .TX_END_O(txe),
		.RX_ENABLE_O(rxen), .RX_VALID_I(rxv), .RX_DATA_I(rxd), .RX_END_I(rxe),
		.KEY_WE_O(kwe), .KEY_INDEX_O(kidx), .KEY_DATA_O(kd));
	rcs_far_model far_u (
		.clock_i(clk), .rst_n_i(rst_n), .pop_i(pop), .push_i(push), .push_data_i(pushd),
		.valid_o(qv), .data_o(qd), .tx_valid_i(txv), .tx_data_i(txd), .tx_ready_o(txr),
		.rx_valid_o(rxv), .rx_data_o(rxd), .rx_end_o(rxe),
		.key_we_i(kwe), .key_index_i(kidx), .key_data_i(kd));
	// Free running clock
	always #5 clk = ~clk;
	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic timeout(input string what);
		errors++;
		$display("MISMATCH %s expected answer seen timeout", what);
		print_verdict();
	endtask : timeout
	// Request held until ready is seen at a rising edge; one idle cycle keeps calls apart
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd,
			output logic er);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= 8'(idx * 4);
		pwdata <= {24'h00_0000, wd};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			if (++k > 20)
				timeout("pready");
			@(posedge clk);
		end
		rd = prdata[7:0];
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] r;
		logic e;
		apb(1'b1, idx, d, r, e);
	endtask : wr
	task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] v;
		logic e;
		apb(1'b0, idx, 8'h00, v, e);
		chk(what, exp, v);
	endtask : rchk
	task automatic wait_idle;
		logic [7:0] v;
		logic e;
		for (int k = 0; k < 100; k++) begin
			apb(1'b0, `RCS_IDX_CMD, 8'h00, v, e);
			if (v === `RCS_OP_IDLE)
				return;
		end
		timeout("cmd idle");
	endtask : wait_idle
	task automatic qchk(input string what, input logic exp);
		@(negedge clk);
		chk(what, exp, qv);
		@(posedge clk);
	endtask : qchk
	task automatic t_power_up_init_op;
		logic [7:0] v;
		logic e;
		far_u.put(8'h11);
		far_u.put(8'h12);
		far_u.put(8'h13);
		rchk("cmd in init", `RCS_IDX_CMD, `RCS_OP_POWER_UP_INIT_OP);
		wr(`RCS_IDX_CMD, `RCS_OP_TX);
		wait_idle();
		qchk("queue after init", 1'b1);
		rchk("guard reset", `RCS_IDX_GUARD, `RCS_RST_GUARD);
		rchk("spare a", `RCS_IDX_SPARE_A, 8'h00);
		rchk("spare b", `RCS_IDX_SPARE_B, 8'h00);
		apb(1'b0, 8'h02, 8'h00, v, e);
		chk("unmapped error", 1, e);
		wr(`RCS_IDX_CMD, `RCS_OP_POWER_UP_INIT_OP);
		rchk("host init code", `RCS_IDX_CMD, `RCS_OP_IDLE);
		rchk("busy after host init code", `RCS_IDX_STATUS, 8'h00);
		wr(`RCS_IDX_CMD, 8'h05);
		rchk("unknown code", `RCS_IDX_CMD, `RCS_OP_IDLE);
		far_u.slow = 1'b1;
		wr(`RCS_IDX_CMD, `RCS_OP_TX);
		wait_idle();
		chk("tx count", 3, far_u.txd.size());
		for (int i = 0; i < 3; i++)
			chk("tx byte", 8'h11 + 8'(i), far_u.txd[i]);
		far_u.slow = 1'b0;
		$display("test power_up_init_op and transmit done");
	endtask : t_power_up_init_op
	task automatic t_rx(input logic [7:0] op);
		int n;
		int lo;
		n = 0;
		lo = (op == `RCS_OP_TRX) ? 3 * TICK : 3 * TICK - 2;
		far_u.txd.delete();
		far_u.pushed.delete();
		if (op == `RCS_OP_TRX) begin
			far_u.put(8'h31);
			far_u.put(8'h32);
		end
		wr(`RCS_IDX_GUARD, 8'h03);
		wr(`RCS_IDX_CMD, op);
		while (op == `RCS_OP_TRX && txe !== 1'b1) begin
			if (++n > 200)
				timeout("tx end");
			@(negedge clk);
		end
		n = 0;
		while (rxen !== 1'b1) begin
			if (++n > 300)
				timeout("rx enable");
			@(negedge clk);
		end
		chk("guard delay", 1, n >= lo && n <= lo + 6);
		chk("tx count", (op == `RCS_OP_TRX) ? 2 : 0, far_u.txd.size());
		@(posedge clk);
		far_u.reply({8'hC1, 8'hC2});
		wait_idle();
		chk("rx enable off", 0, rxen);
		chk("rx count", 2, far_u.pushed.size());
		chk("rx byte 0", 8'hC1, far_u.pushed[0]);
		chk("rx byte 1", 8'hC2, far_u.pushed[1]);
		$display("test receive %h done", op);
	endtask : t_rx
	task automatic t_nvm;
		far_u.pushed.delete();
		far_u.put(8'h10);
		far_u.put(8'h00);
		wr(`RCS_IDX_CMD, `RCS_OP_NVW);
		for (int i = 0; i < KB; i++)
			far_u.put(8'hA0 + 8'(i));
		for (int k = 0; qv !== 1'b0; k++) begin
			if (k > 200)
				timeout("nvm drain");
			@(posedge clk);
		end
		repeat (8) @(posedge clk);
		rchk("write runs on", `RCS_IDX_CMD, `RCS_OP_NVW);
		wr(`RCS_IDX_CMD, `RCS_OP_IDLE);
		far_u.put(8'h10);
		repeat (10) @(posedge clk);
		qchk("queue after cancel", 1'b1);
		far_u.put(8'h00);
		wr(`RCS_IDX_CMD, `RCS_OP_NVR);
		repeat (20) @(posedge clk);
		chk("push before count", 0, far_u.pushed.size());
		rchk("waits for count", `RCS_IDX_CMD, `RCS_OP_NVR);
		far_u.put(8'h03);
		wait_idle();
		chk("nvr count", 3, far_u.pushed.size());
		for (int i = 0; i < 3; i++)
			chk("nvr byte", 8'hA0 + 8'(i), far_u.pushed[i]);
		far_u.pushed.delete();
		far_u.put(8'h80);
		far_u.put(8'h00);
		far_u.put(8'h01);
		wr(`RCS_IDX_CMD, `RCS_OP_NVR);
		wait_idle();
		chk("key read push", 0, far_u.pushed.size());
		rchk("refused flag", `RCS_IDX_STATUS, 8'(1 << `RCS_STAT_REFUSED));
		$display("test nvm done");
	endtask : t_nvm
	task automatic t_key(input logic [7:0] op, input logic [7:0] base);
		far_u.nkey = 0;
		if (op == `RCS_OP_KEYN) begin
			far_u.put(8'h10);
			far_u.put(8'h00);
		end else begin
			for (int i = 0; i < KB; i++)
				far_u.put(base + 8'(i));
		end
		wr(`RCS_IDX_CMD, op);
		wait_idle();
		chk("key count", KB, far_u.nkey);
		for (int i = 0; i < KB; i++)
			chk("key byte", base + 8'(i), far_u.keys[i]);
		$display("test key %h done", op);
	endtask : t_key
	// Hard reset in mid-run must rerun init and restore defaults
	task automatic t_reset;
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rchk("cmd after reset", `RCS_IDX_CMD, `RCS_OP_POWER_UP_INIT_OP);
		wait_idle();
		rchk("guard after reset", `RCS_IDX_GUARD, `RCS_RST_GUARD);
		rchk("status after reset", `RCS_IDX_STATUS, 8'h00);
		$display("test reset done");
	endtask : t_reset
	// Reset, then every scenario in turn
	initial begin
		rst_n <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0000_0000;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_power_up_init_op();
		t_rx(`RCS_OP_TRX);
		t_rx(`RCS_OP_RX);
		t_nvm();
		t_key(`RCS_OP_KEYN, 8'hA0);
		t_key(`RCS_OP_KEYQ, 8'h50);
		t_reset();
		print_verdict();
	end
endmodule : test_reader_command_sequencer
